// ---- core/uiem_gate.sv ----
// uiem_gate: masks event flags with their enables and merges them
// assumes flags and enables are on aclk
`timescale 1ns/1ps
module uiem_gate
  import uiem_pkg::*;
(
  // flags and enables
  input  wire uiem_flags_t flags,
  input  wire logic [7:0]  enables,
  // merged request
  output logic             req
);

  assign req = |(flags & enables);

endmodule

// ---- core/uiem_pkg.sv ----
// uiem_pkg: shared constants and types of the usb interrupt enable mask
// assumes a 32-bit axi4-lite register bus
package uiem_pkg;

  localparam int          UIEM_AW          = 4;
  localparam int          UIEM_DW          = 32;
  localparam int          UIEM_NEV         = 8;
  // register byte offsets
  localparam logic [3:0]  UIEM_OFF_ENABLE  = 4'h0;
  localparam logic [3:0]  UIEM_OFF_FLAGS   = 4'h4;
  localparam logic [3:0]  UIEM_OFF_STATUS  = 4'h8;
  localparam logic [3:0]  UIEM_OFF_IMASK   = 4'hc;
  // enable bit positions
  localparam int          UIEM_B_RESET     = 0;
  localparam int          UIEM_B_ERROR     = 1;
  localparam int          UIEM_B_FRAME     = 2;
  localparam int          UIEM_B_TOKEN     = 3;
  localparam int          UIEM_B_IDLE      = 4;
  localparam int          UIEM_B_RESUME    = 5;
  localparam int          UIEM_B_ATTACH    = 6;
  localparam int          UIEM_B_STALL     = 7;
  // status bit positions
  localparam int          UIEM_S_RISE      = 0;
  localparam int          UIEM_S_ROLE      = 1;
  // reset values and response codes
  localparam logic [7:0]  UIEM_ENABLE_RST  = 8'h00;
  localparam logic [1:0]  UIEM_IMASK_RST   = 2'h0;
  localparam logic [1:0]  UIEM_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  UIEM_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       stall;
    logic       attach;
    logic       resume;
    logic       idle;
    logic       token_done;
    logic       frame_start;
    logic       usb_error;
    logic       reset_or_unplug;
  } uiem_flags_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } uiem_rd_t;

endpackage

// ---- core/uiem_sync.sv ----
// uiem_sync: two-flop synchroniser for a vector of levels
// assumes inputs are asynchronous to aclk
`timescale 1ns/1ps
module uiem_sync
  import uiem_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce) begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule

// ---- core/uiem_top.sv ----
// uiem_top: usb interrupt enable mask with axi4-lite register access
// assumes flags come from usb logic off this clock; host_role is a level
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module uiem_top
  import uiem_pkg::*;
(
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // usb event flags
  input  wire logic        stall_flag,
  input  wire logic        attach_flag,
  input  wire logic        resume_flag,
  input  wire logic        idle_flag,
  input  wire logic        token_done_flag,
  input  wire logic        frame_start_flag,
  input  wire logic        usb_error_flag,
  input  wire logic        bus_reset_flag,
  input  wire logic        unplug_flag,
  input  wire logic        host_role,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // interrupts
  output logic             combined_usb_irq,
  output logic             block_irq
);

  // synchronised flag vector
  logic [9:0]  raw_flags;
  logic [9:0]  sy_flags;
  uiem_flags_t flags;
  logic        sy_host;

  // enable register and its fields
  logic [7:0]  usb_irq_enable_ff;
  logic        stall_event_en;
  logic        attach_event_en;
  logic        resume_event_en;
  logic        bus_idle_en;
  logic        token_done_en;
  logic        frame_start_en;
  logic        usb_error_en;
  logic        bus_reset_en;
  logic        unplug_event_en;

  // merge and interrupt state
  logic        gate_req;
  logic        nxt_irq;
  logic        irq_ff;
  logic        irq_prev_ff;
  logic [1:0]  status_ff;
  logic [1:0]  imask_ff;
  logic        role_prev_ff;
  logic [1:0]  ev_set;
  logic [1:0]  nxt_status;
  logic [31:0] en_word;
  logic [31:0] imask_word;

  // bus state
  logic        aw_held_ff;
  logic        w_held_ff;
  logic [3:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        aw_take;
  logic        w_take;
  logic        wr_fire;
  logic [3:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        rd_fire;
  logic        st_read;
  uiem_rd_t    rd_ans;

  function automatic logic [31:0] merge_bytes(input logic [31:0] cur,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = cur;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] off);
    return {a[3:2], 2'b00} == off;
  endfunction

  assign raw_flags = {host_role, unplug_flag, stall_flag, attach_flag, resume_flag,
                      idle_flag, token_done_flag, frame_start_flag, usb_error_flag,
                      bus_reset_flag};

  uiem_sync #(
    .W (10)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (clk_en),
    .din     (raw_flags),
    .dout    (sy_flags)
  );

  assign sy_host = sy_flags[9];

  assign stall_event_en  = usb_irq_enable_ff[UIEM_B_STALL];
  assign attach_event_en = usb_irq_enable_ff[UIEM_B_ATTACH];
  assign resume_event_en = usb_irq_enable_ff[UIEM_B_RESUME];
  assign bus_idle_en     = usb_irq_enable_ff[UIEM_B_IDLE];
  assign token_done_en   = usb_irq_enable_ff[UIEM_B_TOKEN];
  assign frame_start_en  = usb_irq_enable_ff[UIEM_B_FRAME];
  assign usb_error_en    = usb_irq_enable_ff[UIEM_B_ERROR];
  assign bus_reset_en    = usb_irq_enable_ff[UIEM_B_RESET] & ~sy_host;
  assign unplug_event_en = usb_irq_enable_ff[UIEM_B_RESET] & sy_host;

  always_comb begin
    flags.stall           = sy_flags[7];
    flags.attach          = sy_flags[6];
    flags.resume          = sy_flags[5];
    flags.idle            = sy_flags[4];
    flags.token_done      = sy_flags[3];
    flags.frame_start     = sy_flags[2];
    flags.usb_error       = sy_flags[1];
    flags.reset_or_unplug = sy_host ? sy_flags[8] : sy_flags[0];
  end

  uiem_gate u_gate (
    .flags   (flags),
    .enables ({stall_event_en, attach_event_en, resume_event_en, bus_idle_en,
               token_done_en, frame_start_en, usb_error_en,
               bus_reset_en | unplug_event_en}),
    .req     (gate_req)
  );

  assign nxt_irq = gate_req & usb_error_en;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0;
    end else if (clk_en) begin
      irq_ff <= nxt_irq;
    end
  end

  // previous values for edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_prev_ff  <= 1'b0;
      role_prev_ff <= 1'b0;
    end else if (clk_en) begin
      irq_prev_ff  <= irq_ff;
      role_prev_ff <= sy_host;
    end
  end

  assign combined_usb_irq = irq_ff;

  // write channel capture
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  assign wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
  assign wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
  assign wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb;
  assign wr_fire = (aw_held_ff | aw_take) & (w_held_ff | w_take) & ~s_axi_bvalid;

  // write address and data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff  <= '0;
      w_strb_ff  <= '0;
    end else if (clk_en) begin
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
      end else begin
        if (aw_take) begin
          aw_held_ff <= 1'b1;
          aw_addr_ff <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held_ff <= 1'b1;
          w_data_ff <= s_axi_wdata;
          w_strb_ff <= s_axi_wstrb;
        end
      end
    end
  end

  // write readies, low while held or answering
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else if (clk_en) begin
      s_axi_awready <= ~aw_held_ff & ~aw_take & ~s_axi_bvalid & ~wr_fire;
      s_axi_wready  <= ~w_held_ff & ~w_take & ~s_axi_bvalid & ~wr_fire;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= UIEM_RESP_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (addr_hit(wr_addr, UIEM_OFF_ENABLE) ||
                         addr_hit(wr_addr, UIEM_OFF_IMASK) ||
                         addr_hit(wr_addr, UIEM_OFF_FLAGS) ||
                         addr_hit(wr_addr, UIEM_OFF_STATUS))
                        ? UIEM_RESP_OKAY : UIEM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // written word merged per byte
  assign en_word    = merge_bytes({24'h000000, usb_irq_enable_ff}, wr_data, wr_strb);
  assign imask_word = merge_bytes({30'h0, imask_ff}, wr_data, wr_strb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_irq_enable_ff <= UIEM_ENABLE_RST;
    end else if (clk_en && wr_fire && addr_hit(wr_addr, UIEM_OFF_ENABLE)) begin
      usb_irq_enable_ff <= en_word[7:0];
    end
  end

  // interrupt mask register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      imask_ff <= UIEM_IMASK_RST;
    end else if (clk_en && wr_fire && addr_hit(wr_addr, UIEM_OFF_IMASK)) begin
      imask_ff <= imask_word[1:0];
    end
  end

  // read channel
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign st_read = rd_fire & addr_hit(s_axi_araddr, UIEM_OFF_STATUS);

  always_comb begin
    rd_ans.data = 32'h00000000;
    rd_ans.resp = UIEM_RESP_OKAY;
    if (addr_hit(s_axi_araddr, UIEM_OFF_ENABLE)) begin
      rd_ans.data = {24'h000000, usb_irq_enable_ff};
    end else if (addr_hit(s_axi_araddr, UIEM_OFF_FLAGS)) begin
      rd_ans.data = {22'h0, sy_flags[9:8], flags};
    end else if (addr_hit(s_axi_araddr, UIEM_OFF_STATUS)) begin
      rd_ans.data = {30'h0, status_ff};
    end else if (addr_hit(s_axi_araddr, UIEM_OFF_IMASK)) begin
      rd_ans.data = {30'h0, imask_ff};
    end else begin
      rd_ans.resp = UIEM_RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= UIEM_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= ~s_axi_rvalid & ~rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_ans.data;
        s_axi_rresp  <= rd_ans.resp;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // sticky status, set wins over read clear
  assign ev_set[UIEM_S_RISE] = irq_ff & ~irq_prev_ff;
  assign ev_set[UIEM_S_ROLE] = sy_host ^ role_prev_ff;
  assign nxt_status          = (st_read ? 2'b00 : status_ff) | ev_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= '0;
      block_irq <= 1'b0;
    end else if (clk_en) begin
      status_ff <= nxt_status;
      block_irq <= |(nxt_status & imask_ff);
    end
  end

endmodule

// ---- test/uiem_top_sva.sv ----
// uiem_top_sva: port assertions for the usb interrupt enable mask
// assumes it is bound into uiem_top; shadows hold while clk_en is low
`timescale 1ns/1ps
module uiem_top_sva
  import uiem_pkg::*;
(
  // clock and reset
  input logic        aclk,
  input logic        aresetn,
  input logic        clk_en,
  // usb event flags
  input logic        stall_flag,
  input logic        attach_flag,
  input logic        resume_flag,
  input logic        idle_flag,
  input logic        token_done_flag,
  input logic        frame_start_flag,
  input logic        usb_error_flag,
  input logic        bus_reset_flag,
  input logic        unplug_flag,
  input logic        host_role,
  // register bus
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic [3:0]  s_axi_awaddr,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0]  s_axi_wstrb,
  input logic        s_axi_bvalid,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [3:0]  s_axi_araddr,
  input logic        s_axi_rvalid,
  input logic [31:0] s_axi_rdata,
  // interrupt
  input logic        combined_usb_irq
);
  logic [9:0] p1_ff, p2_ff, p3_ff;
  logic [7:0] en_ff, wd_ff, src;
  logic [3:0] wa_ff, ra_ff;
  logic       bv_ff;
  logic       exp_irq;

  // flag pipe, sync plus output reg
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {p1_ff, p2_ff, p3_ff} <= '0;
    end else if (clk_en) begin
      {p3_ff, p2_ff, p1_ff} <= {p2_ff, p1_ff, host_role, unplug_flag, bus_reset_flag,
        stall_flag, attach_flag, resume_flag, idle_flag, token_done_flag,
        frame_start_flag, usb_error_flag};
    end
  end

  // shadow of the enable register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {en_ff, wd_ff, wa_ff, ra_ff, bv_ff} <= '0;
    end else if (clk_en) begin
      bv_ff <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) wa_ff <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_ff <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : en_ff;
      if (s_axi_arvalid && s_axi_arready) ra_ff <= s_axi_araddr;
      if (s_axi_bvalid && !bv_ff && wa_ff == UIEM_OFF_ENABLE) en_ff <= wd_ff;
    end
  end

  assign src     = {p3_ff[6:0], p3_ff[9] ? p3_ff[8] : p3_ff[7]};
  assign exp_irq = en_ff[1] & (|(src & en_ff));

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_STALL: assert property (en_ff[1] && en_ff[7] && src[7] |-> combined_usb_irq)
    else $error("stall event not forwarded");
  AST_ATTACH: assert property (en_ff[1] && en_ff[6] && src[6] |-> combined_usb_irq)
    else $error("attach event not forwarded");
  AST_TOKEN: assert property (en_ff[1] && en_ff[3] && src[3] |-> combined_usb_irq)
    else $error("token done not forwarded");
  AST_GATE: assert property (!en_ff[1] |-> !combined_usb_irq)
    else $error("irq without error enable");
  AST_DEVROLE: assert property (
    en_ff[1] && en_ff[0] && !p3_ff[9] && p3_ff[7] |-> combined_usb_irq)
    else $error("bus reset not forwarded");
  AST_HOSTROLE: assert property (
    p3_ff[9] && en_ff == 8'h03 && !p3_ff[8] && !p3_ff[0] |-> !combined_usb_irq)
    else $error("bus reset leaked in host role");
  AST_HIGHZERO: assert property (
    s_axi_rvalid && ra_ff == UIEM_OFF_ENABLE |-> s_axi_rdata == {24'h000000, en_ff})
    else $error("enable read back wrong");
  AST_SUM: assert property (combined_usb_irq == exp_irq)
    else $error("combined irq mismatch");

  COV_IRQ: cover property ($rose(combined_usb_irq));
  COV_HOST: cover property (p3_ff[9] && combined_usb_irq);
  COV_RD: cover property (s_axi_rvalid && ra_ff == UIEM_OFF_ENABLE);
endmodule

bind uiem_top uiem_top_sva chk (.*);

// ---- test/usb_interrupt_enable_mask_test.sv ----
// usb_interrupt_enable_mask_test: self-checking bench for uiem_top
// assumes a 125 MHz clock; the bench drives every port itself
`timescale 1ns/1ps
module usb_interrupt_enable_mask_test
  import uiem_pkg::*;
;
`define CHK(a, e) \
  begin \
    n_tests++; \
    if ((a) !== (e)) begin \
      n_mismatch++; \
      $display("Error at %0t: got %h exp %h", $time, (a), (e)); \
    end \
  end

  logic        aclk = 1'b0;
  logic        aresetn, clk_en;
  logic [9:0]  fl;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, combined_usb_irq, block_irq;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          n_tests, n_mismatch, cyc;

  uiem_top uut (
    .*,
    .stall_flag      (fl[7]),
    .attach_flag     (fl[6]),
    .resume_flag     (fl[5]),
    .idle_flag       (fl[4]),
    .token_done_flag (fl[3]),
    .frame_start_flag(fl[2]),
    .usb_error_flag  (fl[1]),
    .bus_reset_flag  (fl[0]),
    .unplug_flag     (fl[8]),
    .host_role       (fl[9])
  );

  always #4 aclk = ~aclk;

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    rsp  = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic t_regs;
    rd(UIEM_OFF_ENABLE);
    `CHK(rd_d, 32'h00000000);
    wr(UIEM_OFF_ENABLE, 32'hffffffff);
    `CHK(rsp, UIEM_RESP_OKAY);
    rd(UIEM_OFF_ENABLE);
    `CHK(rd_d, 32'h000000ff);
    rd(4'h2);
    `CHK(rsp, UIEM_RESP_OKAY);
    `CHK(rd_d, 32'h000000ff);
    wr(UIEM_OFF_ENABLE, 32'h0);
  endtask

  task automatic t_mask;
    logic [31:0] bit_v;
    for (int b = 0; b < 8; b++) begin
      bit_v = 32'h1 << b;
      fl[b] <= 1'b1;
      wr(UIEM_OFF_ENABLE, bit_v | 32'h2);
      wt(2);
      `CHK(combined_usb_irq, 1'b1);
      wr(UIEM_OFF_ENABLE, (b == 1) ? 32'h0 : 32'h2);
      wt(2);
      `CHK(combined_usb_irq, 1'b0);
      wr(UIEM_OFF_ENABLE, 32'hfd);
      wt(2);
      `CHK(combined_usb_irq, 1'b0);
      fl[b] <= 1'b0;
    end
  endtask

  task automatic t_role;
    fl[9] <= 1'b1;
    fl[0] <= 1'b1;
    wr(UIEM_OFF_ENABLE, 32'h3);
    wt(2);
    `CHK(combined_usb_irq, 1'b0);
    fl[8] <= 1'b1;
    fl[0] <= 1'b0;
    wt(4);
    `CHK(combined_usb_irq, 1'b1);
    fl[9] <= 1'b0;
    wt(4);
    `CHK(combined_usb_irq, 1'b0);
    fl[8] <= 1'b0;
  endtask

  task automatic t_status;
    wt(4);
    rd(UIEM_OFF_STATUS);
    `CHK(rd_d, 32'h3);
    rd(UIEM_OFF_STATUS);
    `CHK(rd_d, 32'h0);
    wr(UIEM_OFF_IMASK, 32'h1);
    fl[7] <= 1'b1;
    wr(UIEM_OFF_ENABLE, 32'h82);
    wt(4);
    `CHK(block_irq, 1'b1);
    rd(UIEM_OFF_STATUS);
    `CHK(rd_d, 32'h1);
    wt(3);
    `CHK(block_irq, 1'b0);
    wr(UIEM_OFF_IMASK, 32'h0);
    wr(UIEM_OFF_ENABLE, 32'h2);
    wr(UIEM_OFF_ENABLE, 32'h82);
    wt(4);
    `CHK(block_irq, 1'b0);
    rd(UIEM_OFF_STATUS);
    `CHK(rd_d, 32'h1);
    fl[7] <= 1'b0;
  endtask

  task automatic t_freeze;
    wr(UIEM_OFF_ENABLE, 32'h0a);
    clk_en <= 1'b0;
    fl[3]  <= 1'b1;
    wt(6);
    `CHK(combined_usb_irq, 1'b0);
    clk_en <= 1'b1;
    wt(4);
    `CHK(combined_usb_irq, 1'b1);
    rd(UIEM_OFF_FLAGS);
    `CHK(rd_d, 32'h00000008);
    fl[3] <= 1'b0;
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    aresetn = 1'b0;
    clk_en = 1'b1;
    fl = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_mask;
    t_role;
    t_status;
    t_freeze;
    give_verdict;
  end

  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict;
    end
  end
endmodule
